//--- hdl/psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// clock and counter sizing
`define PSC_CLK_MHZ          40
`define PSC_CLK_PERIOD_PS    25000
`define PSC_CNT_W            24
`define PSC_ADDR_W           8

// timing figures in their own units
`define PSC_T_POR_US         3000
`define PSC_T_STATUS_MIN_US  70
`define PSC_T_STATUS_MAX_US  230
`define PSC_T_RESTART_MAX_US 80
`define PSC_T_CD2UM_MIN_US   300
`define PSC_T_CLK_MIN_PS     7500
`define PSC_CD2CU_PERIODS    4
`define PSC_USR_CYCLES       12'hc6c

// derived cycle counts at the aclk rate
`define PSC_POR_CYC          24'(`PSC_T_POR_US * `PSC_CLK_MHZ)
`define PSC_STATUS_MIN_CYC   24'(`PSC_T_STATUS_MIN_US * `PSC_CLK_MHZ)
`define PSC_RESTART_CYC      24'(`PSC_T_RESTART_MAX_US * `PSC_CLK_MHZ)
`define PSC_CD2UM_CYC        24'(`PSC_T_CD2UM_MIN_US * `PSC_CLK_MHZ)
`define PSC_CD2CU_CYC        24'((`PSC_CD2CU_PERIODS * `PSC_T_CLK_MIN_PS + `PSC_CLK_PERIOD_PS - 1) / `PSC_CLK_PERIOD_PS)
`define PSC_GUARD_CYC        24'h000004

// register byte offsets
`define PSC_OFF_CTRL         8'h00
`define PSC_OFF_LENGTH       8'h04
`define PSC_OFF_STATUS       8'h08
`define PSC_OFF_BITCNT       8'h0c
`define PSC_OFF_DATA         8'h10

// field positions
`define PSC_CTRL_AUTO_RESTART 0
`define PSC_CTRL_USER_CLK     1
`define PSC_CTRL_INJECT_ERR   2
`define PSC_STAT_USER_MODE    4
`define PSC_STAT_ERROR        5
`define PSC_STAT_PINS         8

// reset values
`define PSC_CTRL_RST         2'h0
`define PSC_LENGTH_RST       32'h00000100

// bus answers
`define PSC_RESP_OKAY        2'h0
`define PSC_RESP_SLVERR      2'h2

`endif

//--- hdl/psc_pkg.sv
package psc_pkg;

  // loader sequencing states
  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_RESET  = 3'b001,
    ST_CONFIG = 3'b010,
    ST_ERROR  = 3'b011,
    ST_INIT   = 3'b100,
    ST_USER   = 3'b101
  } psc_state_type;

endpackage : psc_pkg

//--- hdl/psc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module psc_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // three flops per pin; the first feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '1;
      sync_ff <= '1;
      last_ff <= '1;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // edges from the settled copies only
  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;

endmodule : psc_pin_sync

`default_nettype wire

//--- hdl/psc_config_slave.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"

module psc_config_slave #(
  parameter logic [`PSC_CNT_W-1:0] POR_CYC   = `PSC_POR_CYC,
  parameter logic [`PSC_CNT_W-1:0] CD2UM_CYC = `PSC_CD2UM_CYC
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`PSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   config_request_n,
  input  wire logic                   config_status_n_i,
  output logic                        config_status_n_o,
  output logic                        config_status_n_oe,
  input  wire logic                   config_complete_i,
  output logic                        config_complete_o,
  output logic                        config_complete_oe,
  input  wire logic                   serial_config_clock,
  input  wire logic                   serial_data,
  input  wire logic                   user_startup_clock,
  input  wire logic                   chain_enable_in_n,
  output logic                        chain_enable_out_n,
  output logic                        user_mode
);
  import psc_pkg::*;

  localparam int P_REQ  = 0;
  localparam int P_STAT = 1;
  localparam int P_DONE = 2;
  localparam int P_SCLK = 3;
  localparam int P_DATA = 4;
  localparam int P_UCLK = 5;
  localparam int P_CHN  = 6;

  psc_state_type          state_ff;
  logic [`PSC_CNT_W-1:0]  cnt_ff;
  logic [11:0]            usr_cnt_ff;
  logic [6:0]             pin_lvl;
  logic [6:0]             pin_rise;
  logic [6:0]             pin_fall;
  logic [1:0]             ctrl_ff;
  logic [31:0]            length_ff;
  logic                   inject_ff;
  logic                   err_flag_ff;
  logic [31:0]            bitcnt_ff;
  logic [31:0]            shift_ff;
  logic                   ext_err;
  logic                   wr_fire;
  logic [`PSC_ADDR_W-1:0] aw_addr_ff;
  logic [31:0]            w_data_ff;
  logic [3:0]             w_strb_ff;
  logic [`PSC_ADDR_W-1:0] wr_word;
  logic [`PSC_ADDR_W-1:0] rd_word;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [31:0]            rd_val;
  logic [31:0]            nxt_length;

  // every pin crosses in through two flops before use
  psc_pin_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({chain_enable_in_n, user_startup_clock, serial_data, serial_config_clock,
               config_complete_i, config_status_n_i, config_request_n}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // a low status line seen while released means another chain member failed;
  // the guard skips the cycles in which our own release is still in the sync flops
  assign ext_err = (!pin_lvl[P_STAT] && cnt_ff >= `PSC_GUARD_CYC) || inject_ff;

  // main sequence: reset, configuration, initialisation, user mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_POR;
      cnt_ff     <= '0;
      usr_cnt_ff <= '0;
    end else if (state_ff != ST_POR && pin_fall[P_REQ]) begin
      state_ff   <= ST_RESET;
      cnt_ff     <= '0;
      usr_cnt_ff <= '0;
    end else begin
      case (state_ff)
        ST_POR: begin
          if (cnt_ff == POR_CYC - 24'h000001) begin
            state_ff <= ST_RESET;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 24'h000001;
          end
        end
        ST_RESET: begin
          // a request held low simply stretches this phase
          if (cnt_ff < `PSC_STATUS_MIN_CYC) begin
            cnt_ff <= cnt_ff + 24'h000001;
          end else if (pin_lvl[P_REQ]) begin
            state_ff <= ST_CONFIG;
            cnt_ff   <= '0;
          end
        end
        ST_CONFIG: begin
          if (cnt_ff < `PSC_GUARD_CYC) begin
            cnt_ff <= cnt_ff + 24'h000001;
          end
          if (ext_err) begin
            state_ff <= ST_ERROR;
            cnt_ff   <= '0;
          end else if (length_ff != 32'h0 && bitcnt_ff == length_ff) begin
            state_ff <= ST_INIT;
            cnt_ff   <= '0;
          end
        end
        ST_ERROR: begin
          // trimmed by the pin delay so the release lands inside the time-out; else only a request leaves
          if (ctrl_ff[`PSC_CTRL_AUTO_RESTART]) begin
            if (cnt_ff == `PSC_RESTART_CYC - `PSC_GUARD_CYC) begin
              state_ff <= ST_CONFIG;
              cnt_ff   <= '0;
            end else begin
              cnt_ff <= cnt_ff + 24'h000001;
            end
          end
        end
        ST_INIT: begin
          if (!pin_lvl[P_DONE]) begin
            cnt_ff     <= '0;
            usr_cnt_ff <= '0;
          end else if (!ctrl_ff[`PSC_CTRL_USER_CLK]) begin
            if (cnt_ff == CD2UM_CYC - 24'h000001) begin
              state_ff <= ST_USER;
            end else begin
              cnt_ff <= cnt_ff + 24'h000001;
            end
          end else if (cnt_ff < `PSC_CD2CU_CYC) begin
            cnt_ff <= cnt_ff + 24'h000001;
          end else if (pin_rise[P_UCLK]) begin
            usr_cnt_ff <= usr_cnt_ff + 12'h001;
            if (usr_cnt_ff == `PSC_USR_CYCLES - 12'h001) begin
              state_ff <= ST_USER;
            end
          end
        end
        ST_USER: begin
          state_ff <= ST_USER;
        end
        default: begin
          state_ff <= ST_POR;
          cnt_ff   <= '0;
        end
      endcase
    end
  end

  // serial data capture; bits past the image length belong to the next device
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt_ff <= '0;
      shift_ff  <= '0;
    end else if (state_ff == ST_POR || state_ff == ST_RESET || state_ff == ST_ERROR) begin
      bitcnt_ff <= '0;
    end else if (state_ff == ST_CONFIG && !pin_lvl[P_CHN] && pin_rise[P_SCLK] && bitcnt_ff < length_ff) begin
      shift_ff  <= {shift_ff[30:0], pin_lvl[P_DATA]};
      bitcnt_ff <= bitcnt_ff + 32'h1;
    end
  end

  // pin drivers, all from flops; open-drain lines only ever pull low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_status_n_o   <= 1'b0;
      config_status_n_oe  <= 1'b1;
      config_complete_o   <= 1'b0;
      config_complete_oe  <= 1'b1;
      chain_enable_out_n  <= 1'b1;
      user_mode           <= 1'b0;
    end else begin
      config_status_n_o  <= 1'b0;
      config_status_n_oe <= (state_ff == ST_POR || state_ff == ST_RESET || state_ff == ST_ERROR);
      config_complete_o  <= 1'b0;
      config_complete_oe <= (state_ff != ST_INIT && state_ff != ST_USER);
      chain_enable_out_n <= !(state_ff == ST_INIT || state_ff == ST_USER);
      user_mode          <= (state_ff == ST_USER);
    end
  end

  // sticky error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flag_ff <= 1'b0;
    end else if (state_ff == ST_CONFIG && ext_err) begin
      err_flag_ff <= 1'b1;
    end else if (wr_fire && wr_word == `PSC_OFF_STATUS && w_strb_ff[0] && w_data_ff[`PSC_STAT_ERROR]) begin
      err_flag_ff <= 1'b0;
    end
  end

  // write channels: address and data taken independently, answer once both are in
  assign wr_word = {aw_addr_ff[`PSC_ADDR_W-1:2], 2'b00};
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit  = (wr_word == `PSC_OFF_CTRL) || (wr_word == `PSC_OFF_LENGTH) || (wr_word == `PSC_OFF_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSC_RESP_OKAY;
      aw_addr_ff    <= '0;
      w_data_ff     <= '0;
      w_strb_ff     <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_ff    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // byte-lane merge for the length register
  always_comb begin
    nxt_length = length_ff;
    for (int b = 0; b < 4; b++) begin
      if (w_strb_ff[b]) begin
        nxt_length[8*b +: 8] = w_data_ff[8*b +: 8];
      end
    end
  end

  // control registers; the error injection bit is a one-cycle pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff   <= `PSC_CTRL_RST;
      length_ff <= `PSC_LENGTH_RST;
      inject_ff <= 1'b0;
    end else begin
      inject_ff <= 1'b0;
      if (wr_fire && wr_word == `PSC_OFF_CTRL && w_strb_ff[0]) begin
        ctrl_ff   <= w_data_ff[1:0];
        inject_ff <= w_data_ff[`PSC_CTRL_INJECT_ERR];
      end
      if (wr_fire && wr_word == `PSC_OFF_LENGTH) begin
        length_ff <= nxt_length;
      end
    end
  end

  // read decode; unmapped words read zero with an error answer
  assign rd_word = {s_axi_araddr[`PSC_ADDR_W-1:2], 2'b00};

  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (rd_word)
      `PSC_OFF_CTRL:   rd_val = {30'h0, ctrl_ff};
      `PSC_OFF_LENGTH: rd_val = length_ff;
      `PSC_OFF_STATUS: rd_val = {17'h0, pin_lvl, 2'h0, err_flag_ff, user_mode, 1'b0, state_ff};
      `PSC_OFF_BITCNT: rd_val = bitcnt_ff;
      `PSC_OFF_DATA:   rd_val = shift_ff;
      default:         rd_hit = 1'b0;
    endcase
  end

  // read channel: one outstanding read, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : psc_config_slave

`default_nettype wire

//--- sim/psc_config_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psc_slave_chk #(
  parameter logic [23:0] CD2UM_CYC = 24'h000028
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic config_request_n,
  input wire logic config_status_n_i,
  input wire logic config_status_n_oe,
  input wire logic config_complete_i,
  input wire logic config_complete_oe,
  input wire logic chain_enable_out_n,
  input wire logic user_mode
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] low_ff;
  logic [15:0] rel_ff;
  logic [15:0] done_ff;
  // run lengths; low_ff and done_ff saturate so a long error wait cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_ff  <= 16'h0000;
      rel_ff  <= 16'h0000;
      done_ff <= 16'h0000;
    end else begin
      low_ff  <= config_status_n_oe ? low_ff + {15'h0000, low_ff != 16'hffff} : 16'h0000;
      rel_ff  <= $rose(config_request_n) ? 16'h0001 :
                 (config_status_n_oe && rel_ff != 16'h0000) ? rel_ff + 16'h0001 : 16'h0000;
      done_ff <= config_complete_i ? done_ff + {15'h0000, done_ff != 16'hffff} : 16'h0000;
    end
  end
  a_done_on_req: assert property ($fell(config_request_n) |-> ##[1:20] config_complete_oe)
    else $error("done line not pulled after request");
  a_stat_on_req: assert property ($fell(config_request_n) |-> ##[1:20] config_status_n_oe)
    else $error("status line not pulled after request");
  a_stat_min: assert property ($fell(config_status_n_oe) |-> low_ff >= 16'h0af0)
    else $error("status low pulse too short");
  a_stat_rel: assert property (rel_ff <= 16'h23f0)
    else $error("status not released in time");
  a_por_hold: assert property ($rose(aresetn) |-> config_status_n_oe [*8])
    else $error("status not held after power-on");
  a_done_chain: assert property ($fell(config_complete_oe) |-> config_status_n_i && !chain_enable_out_n)
    else $error("done released apart from chain output");
  a_user_lines: assert property (user_mode |-> !config_status_n_oe && !config_complete_oe)
    else $error("line pulled in user mode");
  a_user_delay: assert property ($rose(user_mode) |-> {8'h00, done_ff} >= CD2UM_CYC)
    else $error("user mode too soon after done");
  a_err_pull: assert property ($fell(config_status_n_i) && !config_status_n_oe && config_complete_oe
    && !user_mode |-> ##[1:10] config_status_n_oe)
    else $error("error not answered on status");
  c_user: cover property ($rose(user_mode));
  c_err: cover property ($fell(config_status_n_i) && !config_status_n_oe);
  c_chain: cover property ($fell(chain_enable_out_n));
endmodule : psc_slave_chk

bind psc_config_slave psc_slave_chk #(.CD2UM_CYC(CD2UM_CYC)) i_psc_slave_chk (
  .aclk(aclk), .aresetn(aresetn), .config_request_n(config_request_n),
  .config_status_n_i(config_status_n_i), .config_status_n_oe(config_status_n_oe),
  .config_complete_i(config_complete_i), .config_complete_oe(config_complete_oe),
  .chain_enable_out_n(chain_enable_out_n), .user_mode(user_mode)
);
`default_nettype wire

//--- sim/psc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input  wire logic config_status_n,
  output logic      config_request_n,
  output logic      serial_config_clock,
  output logic      serial_data,
  output logic      user_startup_clock
);
  // idle: clock parked low, data driven steady
  initial begin
    config_request_n    <= 1'b1;
    serial_config_clock <= 1'b0;
    serial_data         <= 1'b0;
    user_startup_clock  <= 1'b0;
  end
  // low phase kept past the minimum width
  task automatic pulse_request();
    config_request_n <= 1'b0;
    #600;
    config_request_n <= 1'b1;
  endtask : pulse_request
  // msb first, one bit per rise, clock still between frames
  task automatic send_bits(input logic [31:0] word, input int cnt);
    wait (config_status_n === 1'b1);
    #230us;
    for (int i = cnt - 1; i >= 0; i--) begin
      serial_data <= word[i];
      #100 serial_config_clock <= 1'b1;
      #100 serial_config_clock <= 1'b0;
    end
    serial_data <= 1'b0;
  endtask : send_bits
  // start-up clock runs for cnt periods, then parks low
  task automatic run_uclk(input int cnt);
    repeat (cnt) begin
      #100 user_startup_clock <= 1'b1;
      #100 user_startup_clock <= 1'b0;
    end
  endtask : run_uclk
endmodule : psc_host_model
`default_nettype wire

//--- sim/psc_config_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psc_config_slave_tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } psc_row_type;
  logic        aclk, aresetn, tb_pull, chain_in_n, req_n, sclk, sdata, uclk;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        st_oe, st_o, cd_oe, cd_o, chain_out_n, user_mode;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  wire         status_w, done_w;
  int          err_total = 0;
  int          compares = 0;
  int          n;
  psc_row_type rows [9] = '{'{1'b0, 8'h00, 32'h0, 2'h0}, '{1'b0, 8'h04, 32'h100, 2'h0},
    '{1'b0, 8'h14, 32'h0, 2'h2}, '{1'b1, 8'h0c, 32'h5, 2'h2}, '{1'b1, 8'h18, 32'h1, 2'h2},
    '{1'b1, 8'h04, 32'h10, 2'h0}, '{1'b0, 8'h04, 32'h10, 2'h0}, '{1'b1, 8'h00, 32'h1, 2'h0},
    '{1'b0, 8'h00, 32'h1, 2'h0}};
  // open-drain wires with pull-ups, tied across the chain
  assign status_w = ((st_oe && !st_o) || tb_pull) ? 1'b0 : 1'b1;
  assign done_w   = (cd_oe && !cd_o) ? 1'b0 : 1'b1;
  always #12.5 aclk = ~aclk;
  psc_config_slave #(.POR_CYC(24'h000032), .CD2UM_CYC(24'h000028)) i_psc_config_slave (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .config_request_n(req_n),
    .config_status_n_i(status_w), .config_status_n_o(st_o), .config_status_n_oe(st_oe),
    .config_complete_i(done_w), .config_complete_o(cd_o), .config_complete_oe(cd_oe),
    .serial_config_clock(sclk), .serial_data(sdata), .user_startup_clock(uclk),
    .chain_enable_in_n(chain_in_n), .chain_enable_out_n(chain_out_n), .user_mode(user_mode));
  psc_host_model i_host (.config_status_n(status_w), .config_request_n(req_n),
    .serial_config_clock(sclk), .serial_data(sdata), .user_startup_clock(uclk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // both channels offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 50);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 50);
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : axi_rd
  // bounded wait on status wire (0) or user mode (1)
  task automatic wait_hi(input logic sel, output int cnt);
    cnt = 0;
    while ((sel ? user_mode : status_w) !== 1'b1 && cnt < 20000) begin
      @(posedge aclk);
      cnt++;
    end
  endtask : wait_hi
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // watchdog well past the expected run time
  initial begin
    #2400us;
    err_total++;
    close_out();
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    tb_pull = 1'b0;
    chain_in_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk({28'h0, st_oe, cd_oe, chain_out_n, user_mode}, 32'he);
    foreach (rows[i]) begin
      if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rows[i].r);
      else axi_rd(rows[i].a, rows[i].d, rows[i].r);
    end
    $display("register table done");
    i_host.send_bits(32'h0000a5c3, 16);
    wait_hi(1'b1, n);
    chk({29'h0, user_mode, chain_out_n, cd_oe}, 32'h4);
    axi_rd(8'h10, 32'h0000a5c3, 2'h0);
    axi_rd(8'h0c, 32'h00000010, 2'h0);
    $display("oscillator start-up done");
    i_host.pulse_request();
    chk({29'h0, user_mode, st_oe, cd_oe}, 32'h3);
    wait_hi(1'b0, n);
    chk({31'h0, n >= 32'h0ad2 && n <= 32'h23f0}, 32'h1);
    $display("reconfiguration from user mode done");
    fork
      i_host.send_bits(32'h0000ffff, 16);
      begin
        #231us;
        @(posedge aclk);
        tb_pull <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({31'h0, st_oe}, 32'h1);
        tb_pull <= 1'b0;
        wait_hi(1'b0, n);
        chk({31'h0, n > 0 && n <= 32'h0c80}, 32'h1);
      end
    join
    $display("error restart done");
    axi_rd(8'h08, 32'h00000322, 2'h0);
    axi_wr(8'h08, 32'h00000020, 2'h0);
    axi_rd(8'h08, 32'h00000302, 2'h0);
    axi_wr(8'h00, 32'h00000004, 2'h0);
    repeat (3300) @(posedge aclk);
    chk({31'h0, st_oe}, 32'h1);
    $display("error flag and held error done");
    axi_wr(8'h00, 32'h3, 2'h0);
    i_host.pulse_request();
    i_host.send_bits(32'h00001234, 16);
    #1us;
    i_host.run_uclk(3179);
    repeat (10) @(posedge aclk);
    chk({31'h0, user_mode}, 32'h0);
    i_host.run_uclk(1);
    repeat (10) @(posedge aclk);
    chk({31'h0, user_mode}, 32'h1);
    $display("user clock start-up done");
    close_out();
  end
endmodule : psc_config_slave_tb
`default_nettype wire
